// [inc/rsm_pkg.sv]
// Constants and types shared by the reset and supply monitor
`default_nettype none
package rsm_pkg;
  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS        = 10;
  localparam int FILTER_NS            = 2000;
  localparam int FILTER_CYCLES        = (FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POWERON_DELAY_NS     = 10000000;
  localparam int POWERON_DELAY_CYCLES = POWERON_DELAY_NS / CLK_PERIOD_NS;
  localparam int STABLE_NS            = 16000000;
  localparam int STABLE_CYCLES        = STABLE_NS / CLK_PERIOD_NS;
  localparam int PROC_CYCLES          = 5;
  // ==========================================================
  // Register map, index times four is the byte address
  localparam int          ADDR_W   = 12;
  localparam logic [9:0]  IDX_LSI  = 10'h086;
  localparam logic [9:0]  IDX_BO   = 10'h0d8;
  localparam logic [9:0]  IDX_FLG  = 10'h0e8;
  localparam logic [9:0]  IDX_IST  = 10'h0f0;
  localparam logic [9:0]  IDX_IEN  = 10'h0f1;
  localparam logic [9:0]  IDX_ICLR = 10'h0f2;
  localparam logic [7:0]  LSI_RST  = 8'h00;
  localparam logic [7:0]  BO_RST   = 8'h00;
  localparam logic [7:0]  FLG_RST  = 8'h80;
  localparam logic [7:0]  IRQ_RST  = 8'h00;
  // ==========================================================
  // Field positions
  localparam int FLG_POR  = 7;
  localparam int FLG_PIN  = 6;
  localparam int FLG_WDT  = 5;
  localparam int FLG_DBG  = 4;
  localparam int FLG_BO   = 3;
  localparam int FLG_LSI  = 2;
  localparam int LSI_FLAG = 5;
  localparam int LSI_EN   = 4;
  localparam int BO_WAKE  = 7;
  localparam int BO_LVL   = 1;
  localparam int BO_DIS   = 0;
  localparam logic [3:0] BO_LVL_MAX  = 4'hd;
  localparam logic [3:0] LSI_LVL_MAX = 4'hc;
  // ==========================================================
  // Core start state and bus answers
  localparam logic [15:0] PC_RST      = 16'h0000;
  localparam logic [7:0]  SP_RST      = 8'h07;
  localparam logic [7:0]  ACC_RST     = 8'h00;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef enum logic [5:0] {
    ST_HOLD = 6'h01,
    ST_PWR  = 6'h02,
    ST_CFG  = 6'h04,
    ST_STAB = 6'h08,
    ST_PROC = 6'h10,
    ST_RUN  = 6'h20
  } seq_state_t;

  typedef enum logic [2:0] {
    SEL_NONE = 3'h0,
    SEL_LSI  = 3'h1,
    SEL_BO   = 3'h2,
    SEL_FLG  = 3'h3,
    SEL_IST  = 3'h4,
    SEL_IEN  = 3'h5,
    SEL_ICLR = 3'h6
  } reg_sel_t;
endpackage : rsm_pkg
`default_nettype wire

// [rtl/pin_noise_filter.sv]
// Low-pulse filter for the external reset pin
`default_nettype none
module pin_noise_filter #(
  parameter int CYCLES = rsm_pkg::FILTER_CYCLES
) (
  input  wire logic i_mclk,
  input  wire logic i_rstn,
  input  wire logic i_pin_low,
  output logic      o_active
);
  localparam int W = $clog2(CYCLES + 1);
  logic [W-1:0] cnt_q;

  // Any high sample restarts the count, so glitches never add up
  always_ff @(posedge i_mclk)
  begin
    if (!i_rstn)
      cnt_q <= '0;
    else if (!i_pin_low)
      cnt_q <= '0;
    else if (cnt_q != W'(CYCLES))
      cnt_q <= cnt_q + 1'b1;
  end

  assign o_active = (cnt_q == W'(CYCLES));

  a_filter_min_low: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    $rose(o_active) |-> $past(i_pin_low, 1) && $past(i_pin_low, CYCLES))
    else $error("pin reset taken after too short a low");

  a_filter_high_drop: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    !i_pin_low |=> !o_active)
    else $error("pin reset stays after pin went high");
endmodule : pin_noise_filter
`default_nettype wire

// [rtl/seq_delay_timer.sv]
// Down counter for the release delays
`default_nettype none
module seq_delay_timer #(
  parameter int W = 21
) (
  input  wire logic         i_mclk,
  input  wire logic         i_rstn,
  input  wire logic         i_load,
  input  wire logic [W-1:0] i_len,
  output logic              o_zero
);
  logic [W-1:0] cnt_q;

  always_ff @(posedge i_mclk)
  begin
    if (!i_rstn)
      cnt_q <= '0;
    else if (i_load)
      cnt_q <= i_len;
    else if (cnt_q != '0)
      cnt_q <= cnt_q - 1'b1;
  end

  assign o_zero = (cnt_q == '0);

  a_timer_loads: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    i_load |=> cnt_q == $past(i_len))
    else $error("delay timer missed its load");

  a_timer_counts: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    !i_load && cnt_q != '0 |=> cnt_q == $past(cnt_q) - 1'b1)
    else $error("delay timer did not count down");
endmodule : seq_delay_timer
`default_nettype wire

// [rtl/reset_and_supply_monitor.sv]
// Reset sequencer, reset cause flags and supply monitor registers
`default_nettype none
module reset_and_supply_monitor #(
  parameter int POWERON_DELAY_CYCLES = rsm_pkg::POWERON_DELAY_CYCLES,
  parameter int STABLE_CYCLES        = rsm_pkg::STABLE_CYCLES,
  parameter int FILTER_CYCLES        = rsm_pkg::FILTER_CYCLES
) (
  input  wire logic        i_mclk,
  input  wire logic        i_rstn,
  input  wire logic        i_reset_pin_low,
  input  wire logic        i_poweron_detect,
  input  wire logic        i_watchdog_overflow,
  input  wire logic        i_watchdog_reset_enable,
  input  wire logic        i_brownout_trip,
  input  wire logic        i_debug_reset,
  input  wire logic        i_low_supply_trip,
  input  wire logic        i_stop_release,
  input  wire logic        i_flash_ready,
  input  wire logic [7:0]  i_config_data,
  input  wire logic [11:0] i_awaddr,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  output logic [1:0]       o_bresp,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  input  wire logic [11:0] i_araddr,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  output logic             o_core_rst_n,
  output logic [15:0]      o_reset_pc,
  output logic [7:0]       o_reset_sp,
  output logic [7:0]       o_reset_acc,
  output logic [7:0]       o_config_q,
  output logic             o_config_valid,
  output logic             o_brownout_disable,
  output logic [3:0]       o_brownout_level_sel,
  output logic             o_low_supply_detect_en,
  output logic [3:0]       o_low_supply_level_sel,
  output logic             o_irq
);
  localparam int MAXD = (POWERON_DELAY_CYCLES > STABLE_CYCLES) ?
                        POWERON_DELAY_CYCLES : STABLE_CYCLES;
  localparam int TW   = $clog2(MAXD + 1);

  function automatic rsm_pkg::reg_sel_t decode(input logic [11:0] addr);
    rsm_pkg::reg_sel_t s;
    s = rsm_pkg::SEL_NONE;
    if (addr[1:0] == 2'h0)
    begin
      case (addr[11:2])
        rsm_pkg::IDX_LSI:  s = rsm_pkg::SEL_LSI;
        rsm_pkg::IDX_BO:   s = rsm_pkg::SEL_BO;
        rsm_pkg::IDX_FLG:  s = rsm_pkg::SEL_FLG;
        rsm_pkg::IDX_IST:  s = rsm_pkg::SEL_IST;
        rsm_pkg::IDX_IEN:  s = rsm_pkg::SEL_IEN;
        rsm_pkg::IDX_ICLR: s = rsm_pkg::SEL_ICLR;
        default:           s = rsm_pkg::SEL_NONE;
      endcase
    end
    return s;
  endfunction : decode

  rsm_pkg::seq_state_t state_q;
  rsm_pkg::reg_sel_t   wsel;
  logic [7:0]    lsi_q, bo_q, flg_q, ist_q, ien_q, cfg_q;
  logic [4:0]    src, src_prev_q, ev;
  logic          pin_act, any_src, por_seen_q, cfg_ok_q, core_rst_n_q, irq_q;
  logic [2:0]    proc_cnt_q;
  logic          tmr_load, tmr_zero, cfg_done;
  logic [TW-1:0] tmr_len;
  logic          aw_have_q, w_have_q, awready_q, wready_q, bvalid_q;
  logic          arready_q, rvalid_q, wr_go, wr_lane;
  logic [11:0]   awaddr_q;
  logic [7:0]    wbyte_q;
  logic          wstrb0_q;
  logic [1:0]    bresp_q, rresp_q;
  logic [31:0]   rdata_q;
  logic          lsi_set;

  // ==========================================================
  // Reset sources
  pin_noise_filter #(.CYCLES(FILTER_CYCLES)) u_filter (
    .i_mclk    (i_mclk),
    .i_rstn    (i_rstn),
    .i_pin_low (i_reset_pin_low),
    .o_active  (pin_act)
  );

  // Order matches flag bits 7 down to 3
  assign src = {i_poweron_detect, pin_act,
                i_watchdog_overflow & i_watchdog_reset_enable,
                i_debug_reset,
                i_brownout_trip & ~bo_q[rsm_pkg::BO_DIS]};
  assign any_src = |src;
  assign ev      = src & ~src_prev_q;

  always_ff @(posedge i_mclk)
  begin
    if (!i_rstn)
      src_prev_q <= '0;
    else
      src_prev_q <= src;
  end

  // ==========================================================
  // Release sequence
  assign cfg_done = (state_q == rsm_pkg::ST_CFG) && i_flash_ready && !any_src;
  assign tmr_load = (state_q == rsm_pkg::ST_HOLD) || (state_q == rsm_pkg::ST_CFG);
  assign tmr_len  = ((state_q == rsm_pkg::ST_HOLD) && por_seen_q) ?
                    TW'(POWERON_DELAY_CYCLES) : TW'(STABLE_CYCLES);

  seq_delay_timer #(.W(TW)) u_timer (
    .i_mclk (i_mclk),
    .i_rstn (i_rstn),
    .i_load (tmr_load),
    .i_len  (tmr_len),
    .o_zero (tmr_zero)
  );

  always_ff @(posedge i_mclk)
  begin
    if (!i_rstn)
    begin
      state_q    <= rsm_pkg::ST_HOLD;
      proc_cnt_q <= '0;
    end
    else if (any_src)
      state_q <= rsm_pkg::ST_HOLD;
    else
    begin
      case (state_q)
        rsm_pkg::ST_HOLD:
          state_q <= por_seen_q ? rsm_pkg::ST_PWR : rsm_pkg::ST_STAB;
        rsm_pkg::ST_PWR:
          if (tmr_zero)
            state_q <= rsm_pkg::ST_CFG;
        rsm_pkg::ST_CFG:
          if (i_flash_ready)
            state_q <= rsm_pkg::ST_STAB;
        rsm_pkg::ST_STAB:
          if (tmr_zero)
          begin
            state_q    <= rsm_pkg::ST_PROC;
            proc_cnt_q <= '0;
          end
        rsm_pkg::ST_PROC:
          if (proc_cnt_q == 3'(rsm_pkg::PROC_CYCLES - 1))
            state_q <= rsm_pkg::ST_RUN;
          else
            proc_cnt_q <= proc_cnt_q + 1'b1;
        rsm_pkg::ST_RUN:
          state_q <= rsm_pkg::ST_RUN;
        default:
          state_q <= rsm_pkg::ST_HOLD;
      endcase
    end
  end

  // Only a power-up takes the long path with the configuration read
  always_ff @(posedge i_mclk)
  begin
    if (!i_rstn)
    begin
      por_seen_q <= 1'b1;
      cfg_ok_q   <= 1'b0;
      cfg_q      <= '0;
    end
    else if (i_poweron_detect)
    begin
      por_seen_q <= 1'b1;
      cfg_ok_q   <= 1'b0;
    end
    else if (cfg_done)
    begin
      por_seen_q <= 1'b0;
      cfg_ok_q   <= 1'b1;
      cfg_q      <= i_config_data;
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_rstn)
      core_rst_n_q <= 1'b0;
    else
      core_rst_n_q <= (state_q == rsm_pkg::ST_RUN) && !any_src;
  end

  // Start values handed to the core
  always_ff @(posedge i_mclk)
  begin
    o_reset_pc  <= rsm_pkg::PC_RST;
    o_reset_sp  <= rsm_pkg::SP_RST;
    o_reset_acc <= rsm_pkg::ACC_RST;
  end

  // ==========================================================
  // Registers
  assign wr_go   = aw_have_q && w_have_q && !bvalid_q;
  assign wsel    = decode(awaddr_q);
  assign wr_lane = wr_go && wstrb0_q;
  assign lsi_set = i_low_supply_trip && lsi_q[rsm_pkg::LSI_EN];

  // Set wins over a software clear in the same cycle
  always_ff @(posedge i_mclk)
  begin
    if (!i_rstn)
      flg_q <= rsm_pkg::FLG_RST;
    else if (i_poweron_detect)
    begin
      flg_q[rsm_pkg::FLG_POR] <= 1'b1;
      flg_q[rsm_pkg::FLG_WDT] <= 1'b0;
      flg_q[rsm_pkg::FLG_DBG] <= 1'b0;
      flg_q[rsm_pkg::FLG_BO]  <= 1'b0;
      flg_q[rsm_pkg::FLG_PIN] <= flg_q[rsm_pkg::FLG_PIN] | ev[3];
    end
    else if (wr_lane && wsel == rsm_pkg::SEL_FLG)
      flg_q <= {ev | (flg_q[7:3] & wbyte_q[7:3]), 3'h0};
    else
      flg_q <= {ev | flg_q[7:3], 3'h0};
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_rstn)
      lsi_q <= rsm_pkg::LSI_RST;
    else if (wr_lane && wsel == rsm_pkg::SEL_LSI)
    begin
      lsi_q[rsm_pkg::LSI_EN]   <= wbyte_q[rsm_pkg::LSI_EN];
      lsi_q[rsm_pkg::LSI_FLAG] <= lsi_set | (lsi_q[rsm_pkg::LSI_FLAG] &
                                  wbyte_q[rsm_pkg::LSI_FLAG]);
      if (wbyte_q[3:0] <= rsm_pkg::LSI_LVL_MAX)
        lsi_q[3:0] <= wbyte_q[3:0];
    end
    else if (lsi_set)
      lsi_q[rsm_pkg::LSI_FLAG] <= 1'b1;
  end

  // Unavailable level codes are refused and the old code kept
  always_ff @(posedge i_mclk)
  begin
    if (!i_rstn || i_poweron_detect)
      bo_q <= rsm_pkg::BO_RST;
    else
    begin
      if (wr_lane && wsel == rsm_pkg::SEL_BO)
      begin
        bo_q[rsm_pkg::BO_WAKE] <= wbyte_q[rsm_pkg::BO_WAKE];
        bo_q[rsm_pkg::BO_DIS]  <= wbyte_q[rsm_pkg::BO_DIS];
        if (wbyte_q[4:1] <= rsm_pkg::BO_LVL_MAX)
          bo_q[4:1] <= wbyte_q[4:1];
      end
      if (i_stop_release && bo_q[rsm_pkg::BO_WAKE])
        bo_q[rsm_pkg::BO_DIS] <= 1'b0;
    end
  end

  // ==========================================================
  // Interrupt
  always_ff @(posedge i_mclk)
  begin
    if (!i_rstn)
    begin
      ist_q <= rsm_pkg::IRQ_RST;
      ien_q <= rsm_pkg::IRQ_RST;
      irq_q <= 1'b0;
    end
    else
    begin
      if (wr_lane && wsel == rsm_pkg::SEL_ICLR)
        ist_q <= {ev, lsi_set & ~lsi_q[rsm_pkg::LSI_FLAG], 2'h0} |
                 (ist_q & ~wbyte_q);
      else
        ist_q <= {ev, lsi_set & ~lsi_q[rsm_pkg::LSI_FLAG], 2'h0} | ist_q;
      if (wr_lane && wsel == rsm_pkg::SEL_IEN)
        ien_q <= {wbyte_q[7:2], 2'h0};
      irq_q <= |(ist_q & ien_q);
    end
  end

  // ==========================================================
  // AXI4-Lite slave, one write and one read at a time
  always_ff @(posedge i_mclk)
  begin
    if (!i_rstn)
    begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      bvalid_q  <= 1'b0;
      bresp_q   <= rsm_pkg::RESP_OKAY;
      awaddr_q  <= '0;
      wbyte_q   <= '0;
      wstrb0_q  <= 1'b0;
    end
    else
    begin
      if (i_awvalid && awready_q)
      begin
        aw_have_q <= 1'b1;
        awready_q <= 1'b0;
        awaddr_q  <= i_awaddr;
      end
      if (i_wvalid && wready_q)
      begin
        w_have_q <= 1'b1;
        wready_q <= 1'b0;
        wbyte_q  <= i_wdata[7:0];
        wstrb0_q <= i_wstrb[0];
      end
      if (wr_go)
      begin
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= (wsel == rsm_pkg::SEL_NONE) ? rsm_pkg::RESP_SLVERR : rsm_pkg::RESP_OKAY;
      end
      if (bvalid_q && i_bready)
      begin
        bvalid_q  <= 1'b0;
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_rstn)
    begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= '0;
      rresp_q   <= rsm_pkg::RESP_OKAY;
    end
    else if (i_arvalid && arready_q)
    begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rresp_q   <= rsm_pkg::RESP_OKAY;
      case (decode(i_araddr))
        rsm_pkg::SEL_LSI: rdata_q <= {24'h0, lsi_q};
        rsm_pkg::SEL_BO:  rdata_q <= {24'h0, bo_q};
        rsm_pkg::SEL_FLG: rdata_q <= {24'h0, flg_q};
        rsm_pkg::SEL_IST: rdata_q <= {24'h0, ist_q};
        rsm_pkg::SEL_IEN: rdata_q <= {24'h0, ien_q};
        rsm_pkg::SEL_ICLR: rdata_q <= '0;
        default:
        begin
          rdata_q <= '0;
          rresp_q <= rsm_pkg::RESP_SLVERR;
        end
      endcase
    end
    else if (rvalid_q && i_rready)
    begin
      rvalid_q  <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  assign o_awready              = awready_q;
  assign o_wready               = wready_q;
  assign o_bvalid               = bvalid_q;
  assign o_bresp                = bresp_q;
  assign o_arready              = arready_q;
  assign o_rvalid               = rvalid_q;
  assign o_rdata                = rdata_q;
  assign o_rresp                = rresp_q;
  assign o_core_rst_n           = core_rst_n_q;
  assign o_config_q             = cfg_q;
  assign o_config_valid         = cfg_ok_q;
  assign o_brownout_disable     = bo_q[rsm_pkg::BO_DIS];
  assign o_brownout_level_sel   = bo_q[4:1];
  assign o_low_supply_detect_en = lsi_q[rsm_pkg::LSI_EN];
  assign o_low_supply_level_sel = lsi_q[3:0];
  assign o_irq                  = irq_q;

  // ==========================================================
  // Checks
  a_core_held_src: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    any_src |=> !o_core_rst_n)
    else $error("core reset released while a source is active");

  a_wdt_gated_off: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    state_q == rsm_pkg::ST_RUN && !i_watchdog_reset_enable && src == 5'h0
    |=> o_core_rst_n)
    else $error("disabled watchdog overflow reset the core");

  a_bo_gated_off: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    i_brownout_trip && o_brownout_disable |-> src[0] == 1'b0)
    else $error("disabled brown-out still acts as a source");

  a_proc_five_clk: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    $rose(state_q == rsm_pkg::ST_PROC) ##0 (!any_src)[*5]
    |-> ##1 state_q == rsm_pkg::ST_RUN)
    else $error("release step is not five clocks");

  a_cfg_waits_flash: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    state_q == rsm_pkg::ST_CFG && !i_flash_ready |=> !o_config_valid && !o_core_rst_n)
    else $error("released before the configuration read");

  a_bo_por_only: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    !i_poweron_detect && !i_stop_release && !(wr_lane && wsel == rsm_pkg::SEL_BO)
    |=> $stable(bo_q))
    else $error("brown-out control changed without power-on or write");

  a_wake_enable: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    i_stop_release && bo_q[rsm_pkg::BO_WAKE] |=> !o_brownout_disable)
    else $error("stop release left brown-out disabled");

  a_flag_only_own: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    !i_poweron_detect && ev == 5'h04 && !(wr_lane && wsel == rsm_pkg::SEL_FLG)
    |=> flg_q[rsm_pkg::FLG_WDT] && flg_q[7:6] == $past(flg_q[7:6])
        && flg_q[4:3] == $past(flg_q[4:3]))
    else $error("watchdog reset disturbed other flags");

  a_por_flags: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    i_poweron_detect |=> flg_q[7] && flg_q[5:3] == 3'h0)
    else $error("power-on flag pattern wrong");

  a_flag_clear: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    wr_lane && wsel == rsm_pkg::SEL_FLG && !wbyte_q[5] && !ev[2] && !i_poweron_detect
    |=> !flg_q[rsm_pkg::FLG_WDT])
    else $error("write of zero did not clear a flag");

  a_lsi_sets: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    lsi_set |=> lsi_q[rsm_pkg::LSI_FLAG])
    else $error("low-supply detection did not set its flag");
endmodule : reset_and_supply_monitor
`default_nettype wire

// [testbench/supply_partner.sv]
// Model of the reset pin driver and the supply comparators
`default_nettype none
module supply_partner (
  input  wire logic  i_mclk,
  output logic       o_pin_low,
  output logic       o_poweron_detect,
  output logic       o_brownout_trip,
  output logic       o_low_supply_trip,
  output logic       o_flash_ready,
  output logic [7:0] o_config_data
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Power-up: detector first, flash supply only later
  initial
  begin
    {o_pin_low, o_brownout_trip, o_low_supply_trip, o_flash_ready} = 4'h0;
    o_poweron_detect = 1'b1;
    o_config_data    = 8'h5a;
    repeat (8) @(posedge i_mclk);
    o_poweron_detect <= 1'b0;
    repeat (40) @(posedge i_mclk);
    o_flash_ready <= 1'b1;
  end
  // ==========================================================
  // Hold one source for n cycles; short pin lows break the minimum on purpose
  task automatic hold(input int sel, input int n);
    if (sel == 0)
      o_pin_low <= 1'b1;
    else if (sel == 1)
      o_brownout_trip <= 1'b1;
    else
      o_low_supply_trip <= 1'b1;
    repeat (n) @(posedge i_mclk);
    {o_pin_low, o_brownout_trip, o_low_supply_trip} <= 3'h0;
  endtask : hold
endmodule : supply_partner
`default_nettype wire

// [testbench/tb_top.sv]
// Register-level testbench of the reset and supply monitor
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin miscompares++; \
  $display("BAD t=%0t got=%h exp=%h", $time, a, e); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] LSI = 12'h218, BO = 12'h360, FLG = 12'h3a0;
  localparam logic [11:0] IEN = 12'h3c4, ICL = 12'h3c8;
  logic        clk = 1'b0, rstn = 1'b0, wov = 1'b0, wen = 1'b0, dbg = 1'b0, stp = 1'b0;
  logic        aw = 1'b0, wv = 1'b0, br = 1'b0, ar = 1'b0, rr = 1'b0;
  logic        pin, por, bot, lst, frdy, core_n, irq, awr, wrd, bv, arr, rv, brownout_detector, cv, lse;
  logic [11:0] awa = 12'h0, ara = 12'h0;
  logic [31:0] wd = 32'h0, rdat, d;
  logic [1:0]  bresp, rresp, r;
  logic [7:0]  cfg, sp, acc, cq;
  logic [15:0] pc;
  logic [3:0]  bol, lsl;
  int          miscompares = 0, checked = 0;
  always #5 clk = ~clk;
  supply_partner p (.i_mclk(clk), .o_pin_low(pin), .o_poweron_detect(por),
    .o_brownout_trip(bot), .o_low_supply_trip(lst), .o_flash_ready(frdy), .o_config_data(cfg));
  reset_and_supply_monitor #(.POWERON_DELAY_CYCLES(20), .STABLE_CYCLES(30),
    .FILTER_CYCLES(8)) uut (.i_mclk(clk), .i_rstn(rstn), .i_reset_pin_low(pin),
    .i_poweron_detect(por), .i_watchdog_overflow(wov), .i_watchdog_reset_enable(wen),
    .i_brownout_trip(bot), .i_debug_reset(dbg), .i_low_supply_trip(lst),
    .i_stop_release(stp), .i_flash_ready(frdy), .i_config_data(cfg),
    .i_awaddr(awa), .i_awvalid(aw), .o_awready(awr), .i_wdata(wd), .i_wstrb(4'h1),
    .i_wvalid(wv), .o_wready(wrd), .o_bresp(bresp), .o_bvalid(bv), .i_bready(br),
    .i_araddr(ara), .i_arvalid(ar), .o_arready(arr), .o_rdata(rdat), .o_rresp(rresp),
    .o_rvalid(rv), .i_rready(rr), .o_core_rst_n(core_n), .o_reset_pc(pc),
    .o_reset_sp(sp), .o_reset_acc(acc), .o_config_q(cq), .o_config_valid(cv),
    .o_brownout_disable(brownout_detector), .o_brownout_level_sel(bol), .o_low_supply_detect_en(lse),
    .o_low_supply_level_sel(lsl), .o_irq(irq));
  // ==========================================================
  // Bus tasks; each waits one edge first so no signal is set twice in a step
  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    @(posedge clk);
    {aw, wv, br, awa, wd} <= {3'h7, a, 24'h0, v};
    do
    begin
      @(posedge clk);
      if (awr) aw <= 1'b0;
      if (wrd) wv <= 1'b0;
    end
    while (!bv);
    br <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a);
    @(posedge clk);
    {ar, rr, ara} <= {2'h3, a};
    do
    begin
      @(posedge clk);
      if (arr) ar <= 1'b0;
    end
    while (!rv);
    d = rdat;
    r = rresp;
    rr <= 1'b0;
  endtask : rd
  task automatic ck(input logic [11:0] a, input logic [7:0] e);
    rd(a);
    `CHK({r, d}, {2'h0, 24'h0, e})
  endtask : ck
  // Bounded wait for the core to leave reset
  task automatic rel;
    for (int k = 0; k < 200 && core_n !== 1'b1; k++) @(posedge clk);
    `CHK(core_n, 1'b1)
  endtask : rel
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  task automatic test_done;
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : test_done
  // ==========================================================
  // Tests
  initial
  begin
    tick(6);
    rstn <= 1'b1;
    ck(FLG, 8'h80);
    `CHK(core_n, 1'b0)
    `CHK(cv, 1'b0)
    rel;
    `CHK({pc, sp, acc}, 32'h00000700)
    `CHK({cv, cq}, 9'h15a)
    $display("test power-up done");
    p.hold(0, 4);
    tick(4);
    `CHK(core_n, 1'b1)
    p.hold(0, 12);
    `CHK(core_n, 1'b0)
    tick(30);
    `CHK(core_n, 1'b0)
    rel;
    ck(FLG, 8'hc0);
    wr(FLG, 8'h80);
    ck(FLG, 8'h80);
    $display("test pin done");
    wov <= 1'b1;
    tick(1);
    wov <= 1'b0;
    tick(3);
    `CHK(core_n, 1'b1)
    {wen, wov} <= 2'h3;
    tick(1);
    wov <= 1'b0;
    tick(3);
    `CHK(core_n, 1'b0)
    rel;
    dbg <= 1'b1;
    tick(1);
    dbg <= 1'b0;
    tick(2);
    `CHK(core_n, 1'b0)
    rel;
    ck(FLG, 8'hb0);
    $display("test watchdog and debug done");
    wr(BO, 8'h9b);
    ck(BO, 8'h9b);
    `CHK({brownout_detector, bol}, 5'h1d)
    wr(BO, 8'h9d);
    ck(BO, 8'h9b);
    p.hold(1, 4);
    tick(2);
    `CHK(core_n, 1'b1)
    stp <= 1'b1;
    tick(1);
    stp <= 1'b0;
    ck(BO, 8'h9a);
    p.hold(1, 4);
    rel;
    ck(FLG, 8'hb8);
    ck(BO, 8'h9a);
    $display("test brown-out done");
    wr(LSI, 8'h1c);
    p.hold(2, 2);
    tick(2);
    ck(LSI, 8'h3c);
    wr(LSI, 8'h1d);
    ck(LSI, 8'h1c);
    `CHK({lse, lsl}, 5'h1c)
    // Status is set but masked, so the line must stay low
    `CHK(irq, 1'b0)
    wr(IEN, 8'h48);
    tick(2);
    `CHK(irq, 1'b1)
    wr(ICL, 8'h48);
    tick(2);
    `CHK(irq, 1'b0)
    rd(12'h004);
    `CHK({r, d}, {2'h2, 32'h0})
    $display("test indicator, interrupt and map done");
    test_done;
  end
  // Run takes well under 2000 cycles
  initial
  begin
    tick(20000);
    miscompares++;
    test_done;
  end
endmodule : tb_top
`default_nettype wire
